// ---- hw/qdl_ctrl.sv ----
// quad dac command decode, load pin, mask, hardware and power-on reset control
`timescale 1ns/1ns
`default_nettype none
module qdl_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic load_dac_strobe_n_in,
  input wire logic reset_n_in,
  input wire logic reset_level_select_in,
  output logic [3:0][9:0] dac_code_out,
  output logic [3:0][9:0] input_code_out,
  output logic [3:0] load_mask_out,
  output logic ref_enable_out,
  output logic init_pending_out
);

  // pin synchronisers: bit 4 scl, 3 sda, 2 load strobe, 1 reset_n, 0 strap
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic load_prev_q;
  logic load_seen_high_q;
  logic [2:0] rst_low_cnt_q;
  logic por_pending_q;
  logic strap_mid_q;
  logic [3:0] mask_q;
  logic ref_off_q;
  logic [3:0][9:0] input_q;
  logic [3:0][9:0] dac_q;
  logic [3:0][9:0] input_d;
  logic [3:0][9:0] dac_d;
  qdl_pkg::qdl_frame_t frame;
  logic frame_valid;

  function automatic logic [9:0] clear_code(input logic mid);
    clear_code = mid ? qdl_pkg::CODE_MID_SCALE : qdl_pkg::CODE_ZERO_SCALE;
  endfunction

  wire [4:0] pin_raw = {scl_in, sda_in, load_dac_strobe_n_in, reset_n_in, reset_level_select_in};
  wire scl_s = pin_s2_q[4];
  wire sda_s = pin_s2_q[3];
  wire load_s = pin_s2_q[2];
  wire rstn_s = pin_s2_q[1];
  wire strap_s = pin_s2_q[0];

  qdl_i2c_rx u_rx (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .frame_out(frame),
    .frame_valid_out(frame_valid),
    .sda_oe_out(sda_oe_out)
  );

  // acknowledge drives the line low only
  assign sda_out = 1'b0;

  // hardware reset counts only once held for the least low time
  wire hw_reset = (rst_low_cnt_q >= 3'(qdl_pkg::RST_LOW_CYC));
  // power-on initialisation waits for the reset pin to be released
  wire init_now = por_pending_q & rstn_s;
  wire blocked = por_pending_q | hw_reset;
  wire load_fall = load_prev_q & ~load_s & ~blocked;
  wire load_tied_low = ~load_seen_high_q;
  wire accept = frame_valid & ~blocked;
  wire cmd_write = accept & (frame.cmd == qdl_pkg::CMD_WRITE_INPUT);
  wire cmd_update = accept & (frame.cmd == qdl_pkg::CMD_UPDATE_DAC);
  wire cmd_wr_upd = accept & (frame.cmd == qdl_pkg::CMD_WRITE_UPDATE);
  wire cmd_mask = accept & (frame.cmd == qdl_pkg::CMD_LOAD_MASK);
  wire cmd_soft = accept & (frame.cmd == qdl_pkg::CMD_SOFT_RESET);
  wire cmd_ref = accept & (frame.cmd == qdl_pkg::CMD_REF_SETUP);
  wire [9:0] new_code = frame.data[qdl_pkg::CODE_LSB +: qdl_pkg::CODE_W];
  wire [9:0] por_code = clear_code(init_now ? strap_s : strap_mid_q);
  wire go_por_code = init_now | cmd_soft;

  always_comb begin
    input_d = input_q;
    dac_d = dac_q;
    for (int i = 0; i < qdl_pkg::NUM_CHAN; i++) begin
      if (go_por_code) begin
        input_d[i] = por_code;
        dac_d[i] = por_code;
      end else if (hw_reset) begin
        input_d[i] = clear_code(strap_mid_q);
        dac_d[i] = clear_code(strap_mid_q);
      end else begin
        // channel field is a per-channel bit mask, bit 0 of the nibble is channel A
        if ((cmd_write | cmd_wr_upd) & frame.chan[i]) begin
          input_d[i] = new_code;
        end
        if (cmd_wr_upd & frame.chan[i]) begin
          dac_d[i] = new_code;
        end else if (cmd_write & frame.chan[i] & ~load_s & (load_tied_low | ~mask_q[i])) begin
          dac_d[i] = new_code;
        end else if (cmd_update & frame.chan[i]) begin
          dac_d[i] = input_q[i];
        end else if (load_fall & ~mask_q[i]) begin
          dac_d[i] = input_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_s1_q <= qdl_pkg::PIN_SYNC_RESET;
      pin_s2_q <= qdl_pkg::PIN_SYNC_RESET;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      load_prev_q <= 1'b1;
      load_seen_high_q <= 1'b0;
    end else begin
      load_prev_q <= load_s;
      if (load_s & ~por_pending_q) begin
        load_seen_high_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rst_low_cnt_q <= 3'h0;
    end else if (rstn_s) begin
      rst_low_cnt_q <= 3'h0;
    end else if (rst_low_cnt_q != 3'h7) begin
      rst_low_cnt_q <= rst_low_cnt_q + 3'h1;
    end
  end

  // strap is caught at the end of power-on initialisation
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      por_pending_q <= 1'b1;
      strap_mid_q <= 1'b0;
    end else if (init_now) begin
      por_pending_q <= 1'b0;
      strap_mid_q <= strap_s;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || go_por_code) begin
      mask_q <= qdl_pkg::MASK_RESET;
    end else if (cmd_mask) begin
      mask_q <= frame.data[qdl_pkg::MASK_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || go_por_code) begin
      ref_off_q <= qdl_pkg::REF_OFF_RESET;
    end else if (cmd_ref) begin
      ref_off_q <= frame.data[qdl_pkg::REF_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      input_q <= {qdl_pkg::NUM_CHAN{qdl_pkg::CODE_ZERO_SCALE}};
      dac_q <= {qdl_pkg::NUM_CHAN{qdl_pkg::CODE_ZERO_SCALE}};
    end else begin
      input_q <= input_d;
      dac_q <= dac_d;
    end
  end

  assign dac_code_out = dac_q;
  assign input_code_out = input_q;
  assign load_mask_out = mask_q;
  assign ref_enable_out = ~ref_off_q;
  assign init_pending_out = por_pending_q;

endmodule
`default_nettype wire

// ---- include/qdl_pkg.sv ----
// constants, field layouts and carrier types for the quad dac load and reset control
//
// Functional notes
// - write-input with load pin low updates input and dac register on 24th clock
// - write-input with load pin high changes input only; later pin fall loads dacs
// - load-mask command ignores channel field, loads mask from four low data bits
// - mask bit 3 is channel D, 2 is C, 1 is B, 0 is A
// - mask bits reset to zero so every channel follows the load pin
// - masked channel sees load pin as high; unmasked channel obeys the pin
// - update command copies input n to dac n regardless of pin, input unchanged
// - write-and-update writes input n and dac n regardless of load pin
// - each load pin falling edge copies input to dac on unmasked channels
// - load pin tied low permanently makes the mask bits ignored
// - reset pin low at least 30 ns clears outputs to strap-selected level
// - reset pin low rejects updates; cleared value holds until reprogrammed
// - software reset command returns dac to power-on reset code
// - load pin activity is ignored while power-on reset is in progress
// - reset pin held low at power-up keeps initialisation pending until release
// - power-up level is zero scale or midscale by strap, held until valid write
// - reference on after power-up; setup command bit 0 one turns it off
// - frame is command nibble, channel nibble, then sixteen data bits
package qdl_pkg;

  localparam int NUM_CHAN = 4;
  localparam int CODE_W = 10;

  // command codes in the top nibble of a frame
  localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
  localparam logic [3:0] CMD_REF_SETUP = 4'h7;

  // the 10-bit code sits left-justified in the sixteen data bits
  localparam int CODE_LSB = 6;
  localparam int MASK_LSB = 0;
  localparam int REF_BIT = 0;

  localparam logic [9:0] CODE_ZERO_SCALE = 10'h000;
  localparam logic [9:0] CODE_MID_SCALE = 10'h200;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic REF_OFF_RESET = 1'b0;

  // bus address of this device; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h0C;
  localparam int FRAME_BYTES = 3;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_LOW_NS = 30;
  localparam int RST_LOW_CYC_RAW = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LOW_CYC = (RST_LOW_CYC_RAW < 1) ? 1 : RST_LOW_CYC_RAW;

  // synchronised pin vector reset value: scl, sda, load high; reset_n and strap low
  // reset_n starts low so power-on init waits for the real pin level to arrive
  localparam logic [4:0] PIN_SYNC_RESET = 5'h1C;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] chan;
    logic [15:0] data;
  } qdl_frame_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_ADDR,
    RX_DATA
  } qdl_rx_state_t;

endpackage

// ---- hw/qdl_i2c_rx.sv ----
// two-wire write receiver that assembles 24-bit command frames
`timescale 1ns/1ns
`default_nettype none
module qdl_i2c_rx (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output var qdl_pkg::qdl_frame_t frame_out,
  output logic frame_valid_out,
  output logic sda_oe_out
);

  qdl_pkg::qdl_rx_state_t state_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_idx_q;
  logic [7:0] shift_q;
  logic [7:0] byte0_q;
  logic [7:0] byte1_q;
  logic ack_q;
  logic valid_q;
  qdl_pkg::qdl_frame_t frame_q;

  wire scl_rise = scl_in & ~scl_prev_q;
  wire scl_fall = ~scl_in & scl_prev_q;
  wire start_det = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
  wire stop_det = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
  wire addr_ok = (shift_q == {qdl_pkg::DEV_ADDR, 1'b0});
  wire busy = (state_q != qdl_pkg::RX_IDLE);
  wire in_data = (state_q == qdl_pkg::RX_DATA);
  wire last_byte = (byte_idx_q == 2'(qdl_pkg::FRAME_BYTES - 1));
  wire take_bit = busy & scl_rise & (bit_cnt_q < 4'h8);
  wire ack_begin = busy & scl_fall & (bit_cnt_q == 4'h8);
  wire ack_end = busy & scl_fall & (bit_cnt_q == 4'h9);
  // 24th data clock of a frame
  wire frame_done = take_bit & in_data & last_byte & (bit_cnt_q == 4'h7);

  assign frame_out = frame_q;
  assign frame_valid_out = valid_q;
  assign sda_oe_out = ack_q;

  always_ff @(posedge clk_sys_in) begin
    scl_prev_q <= rst_in ? 1'b1 : scl_in;
    sda_prev_q <= rst_in ? 1'b1 : sda_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      frame_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= frame_done;
      if (frame_done) begin
        frame_q <= qdl_pkg::qdl_frame_t'({byte0_q, byte1_q, shift_q[6:0], sda_in});
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      byte0_q <= 8'h00;
      byte1_q <= 8'h00;
    end else if (ack_end & in_data & (byte_idx_q == 2'h0)) begin
      byte0_q <= shift_q;
    end else if (ack_end & in_data & (byte_idx_q == 2'h1)) begin
      byte1_q <= shift_q;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= qdl_pkg::RX_IDLE;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
    end else if (start_det) begin
      state_q <= qdl_pkg::RX_ADDR;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      ack_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= qdl_pkg::RX_IDLE;
      ack_q <= 1'b0;
    end else if (take_bit) begin
      shift_q <= {shift_q[6:0], sda_in};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (ack_begin) begin
      // other addresses and read requests are not acknowledged
      ack_q <= in_data | addr_ok;
      bit_cnt_q <= 4'h9;
      if (!in_data && !addr_ok) begin
        state_q <= qdl_pkg::RX_IDLE;
      end
    end else if (ack_end) begin
      ack_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      if (in_data) begin
        byte_idx_q <= last_byte ? 2'h0 : byte_idx_q + 2'h1;
      end else begin
        state_q <= qdl_pkg::RX_DATA;
      end
    end
  end

endmodule
`default_nettype wire

// ---- sim/qdl_ctrl_props.sv ----
// assertion checker for the quad dac load and reset control
`timescale 1ns/1ns
`default_nettype none
module qdl_ctrl_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic load_dac_strobe_n_in,
  input wire logic reset_n_in,
  input wire logic reset_level_select_in,
  input wire logic [3:0][9:0] dac_code_out,
  input wire logic [3:0][9:0] input_code_out,
  input wire logic [3:0] load_mask_out,
  input wire logic ref_enable_out,
  input wire logic init_pending_out
);
  wire logic [9:0] clr_code;
  assign clr_code = reset_level_select_in ? qdl_pkg::CODE_MID_SCALE : qdl_pkg::CODE_ZERO_SCALE;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  mask_reset_a: assert property ($fell(rst_in) |-> load_mask_out == 4'h0)
    else $error("mask not zero after reset");
  ref_on_a: assert property ($fell(rst_in) |-> ref_enable_out)
    else $error("reference off after reset");
  pend_reset_a: assert property ($fell(rst_in) |-> init_pending_out)
    else $error("init not pending after reset");
  init_code_a: assert property ($fell(init_pending_out) |-> dac_code_out == {4{clr_code}})
    else $error("wrong power-up code");
  init_hold_a: assert property (!reset_n_in [*4] ##0 init_pending_out |=> init_pending_out)
    else $error("init finished with reset pin low");
  clear_hold_a: assert property ((!reset_n_in && !init_pending_out) [*5] |->
    dac_code_out == {4{clr_code}} && input_code_out == {4{clr_code}})
    else $error("outputs not held at clear code");
  load_copy_a: assert property ($fell(load_dac_strobe_n_in) && load_mask_out == 4'h0
    && !init_pending_out |-> ##6 dac_code_out == input_code_out)
    else $error("load edge did not copy inputs");
  pend_drop_a: assert property ($changed(load_mask_out) || $changed(ref_enable_out)
    |-> !$past(init_pending_out))
    else $error("setup changed while init pending");
endmodule
bind qdl_ctrl qdl_ctrl_props u_props (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .load_dac_strobe_n_in(load_dac_strobe_n_in),
  .reset_n_in(reset_n_in),
  .reset_level_select_in(reset_level_select_in),
  .dac_code_out(dac_code_out),
  .input_code_out(input_code_out),
  .load_mask_out(load_mask_out),
  .ref_enable_out(ref_enable_out),
  .init_pending_out(init_pending_out)
);
`default_nettype wire

// ---- sim/qdl_master.sv ----
// two-wire bus master model that writes command frames to the device
`timescale 1ns/1ns
`default_nettype none
module qdl_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // eight data bits msb first, then a released ninth bit for the acknowledge
  task automatic put(input logic [7:0] b, inout int nak);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = !b[i];
      w(2);
      scl_out = 1'b1;
      w(4);
      scl_out = 1'b0;
      w(2);
    end
    sda_low_out = 1'b0;
    w(2);
    scl_out = 1'b1;
    w(2);
    if (sda_in) nak++;
    w(2);
    scl_out = 1'b0;
    w(2);
  endtask
  task automatic send(input logic [23:0] f, output int nak);
    nak = 0;
    sda_low_out = 1'b1;
    w(4);
    scl_out = 1'b0;
    w(2);
    put({qdl_pkg::DEV_ADDR, 1'b0}, nak);
    put(f[23:16], nak);
    put(f[15:8], nak);
    put(f[7:0], nak);
    sda_low_out = 1'b1;
    w(4);
    scl_out = 1'b1;
    w(4);
    sda_low_out = 1'b0;
    w(4);
  endtask
endmodule
`default_nettype wire

// ---- sim/quad_dac_load_reset_control_tb.sv ----
// self-checking bench for the quad dac load and reset control
`timescale 1ns/1ns
`default_nettype none
module quad_dac_load_reset_control_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ld_n = 1'b1;
  logic rst_n = 1'b1;
  logic strap = 1'b0;
  logic tied = 1'b0;
  logic scl, m_low, sda_oe, sda_o, ref_on, pend, er;
  wire logic sda;
  logic [3:0][9:0] dac, inp, ed, ei;
  logic [3:0] mask, em;
  int errors = 0;
  int cmp_count = 0;
  int nak;
  // bit 24 set means the load pin is low during the frame
  logic [24:0] rows [9] = '{
    25'h0115540,
    25'h032AA80,
    25'h0210000,
    25'h11240C0,
    25'h01CFFC0,
    25'h0550009,
    25'h07F0001,
    25'h0700000,
    25'h00F5540};
  always #20 clk_sys_in = ~clk_sys_in;
  assign sda = (m_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  qdl_master u_m (.clk_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
  qdl_ctrl uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .load_dac_strobe_n_in(ld_n), .reset_n_in(rst_n),
    .reset_level_select_in(strap), .dac_code_out(dac), .input_code_out(inp),
    .load_mask_out(mask), .ref_enable_out(ref_on), .init_pending_out(pend));
  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check_all();
    chk(inp, ei);
    chk(dac, ed);
    chk({mask, ref_on, pend}, {em, er, 1'b0});
  endtask
  task automatic wc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic model_clr();
    for (int i = 0; i < 4; i++) begin
      ei[i] = strap ? 10'h200 : 10'h000;
      ed[i] = ei[i];
    end
  endtask
  task automatic model_por();
    model_clr();
    em = 4'h0;
    er = 1'b1;
  endtask
  task automatic wait_init();
    for (int n = 0; n < 50 && pend !== 1'b0; n++) wc(1);
    if (pend !== 1'b0) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic set_ld(input logic v);
    if (ld_n && !v) for (int i = 0; i < 4; i++) if (!em[i]) ed[i] = ei[i];
    ld_n = v;
    wc(10);
  endtask
  task automatic frame(input logic [23:0] f, input logic take);
    logic [3:0] c;
    logic [9:0] code;
    c = f[19:16];
    code = f[15:6];
    u_m.send(f, nak);
    chk(nak, 0);
    wc(8);
    if (take) begin
      case (f[23:20])
        4'h1: for (int i = 0; i < 4; i++) if (c[i]) begin
          ei[i] = code;
          if (!ld_n && (!em[i] || tied)) ed[i] = code;
        end
        4'h2: for (int i = 0; i < 4; i++) if (c[i]) ed[i] = ei[i];
        4'h3: for (int i = 0; i < 4; i++) if (c[i]) begin
          ei[i] = code;
          ed[i] = code;
        end
        4'h5: em = f[3:0];
        4'h6: model_por();
        4'h7: er = !f[0];
        default: ;
      endcase
    end
    check_all();
  endtask
  initial begin
    model_por();
    wc(6);
    rst_in = 1'b0;
    wait_init();
    check_all();
    foreach (rows[k]) begin
      set_ld(!rows[k][24]);
      frame(rows[k][23:0], 1'b1);
    end
    set_ld(1'b1);
    set_ld(1'b0);
    check_all();
    set_ld(1'b1);
    wc(4);
    rst_n = 1'b0;
    wc(8);
    // the clear level is the strap caught at power-on init
    model_clr();
    check_all();
    frame(24'h3F0040, 1'b0);
    rst_n = 1'b1;
    wc(6);
    check_all();
    frame(24'h55000F, 1'b1);
    frame(24'h7F0001, 1'b1);
    frame(24'h3F0040, 1'b1);
    frame(24'h600000, 1'b1);
    rst_in = 1'b1;
    rst_n = 1'b0;
    ld_n = 1'b0;
    // strap only moves while power-on reset holds, as a tied pin would
    strap = 1'b1;
    wc(6);
    rst_in = 1'b0;
    tied = 1'b1;
    wc(12);
    chk(pend, 1);
    rst_n = 1'b1;
    wait_init();
    model_por();
    check_all();
    frame(24'h55000F, 1'b1);
    frame(24'h110C40, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
